// ---- pkg/blink_pkg.sv ----
package blink_pkg;

   // Clock and timing
   localparam int CLK_HZ          = 125_000_000;
   localparam int TIMER_DIV       = 512;
   localparam int FILTER_DIV      = 64;
   localparam int FILTER_SAMPLES  = 3;
   localparam int BLINK_PERIOD_MS = 500;
   localparam int MS_PER_S        = 1000;
   // Divided ticks per blink period, rounded down
   localparam int CMP_TICKS       = (CLK_HZ / TIMER_DIV) * BLINK_PERIOD_MS / MS_PER_S;
   localparam int SYNC_STAGES     = 2;
   localparam int IRQ_LEVEL       = 15;

   // Counter widths
   localparam int PRE_W  = 9;
   localparam int CMP_W  = 17;
   localparam int FDIV_W = 6;
   localparam int HIST_W = 3;

   // Register offsets (byte addresses)
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_STATE  = 8'h04;
   localparam logic [7:0] OFF_STATUS = 8'h08;
   localparam logic [7:0] OFF_MASK   = 8'h0C;
   localparam logic [7:0] OFF_PRIO   = 8'h10;
   localparam logic [7:0] OFF_COUNT  = 8'h14;

   // Fields and reset values
   localparam int EVT_TIMER  = 0;
   localparam int EVT_SWITCH = 1;
   localparam int CTRL_RUN   = 0;
   localparam int ST_MANUAL  = 0;
   localparam int ST_FIRST   = 1;
   localparam int ST_SECOND  = 2;
   localparam int ST_VALID   = 3;
   localparam int PRIO_SW_LSB = 4;
   localparam logic        CTRL_RUN_RESET = 1'h1;
   localparam logic [1:0]  MASK_RESET     = 2'h0;
   localparam logic [3:0]  PRIO_VALUE     = 4'hF;
   localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
   localparam logic        HRESP_OKAY     = 1'h0;

   // Indicator outputs, high means lit
   typedef struct packed {
      logic indicatorFirst;
      logic indicatorSecond;
   } ledPair_type;

   typedef struct packed {
      logic        hsel;
      logic [31:0] haddr;
      logic [1:0]  htrans;
      logic        hwrite;
      logic [2:0]  hsize;
      logic [31:0] hwdata;
      logic        hready;
   } ahbReq_type;

   typedef struct packed {
      logic        hreadyout;
      logic        hresp;
      logic [31:0] hrdata;
   } ahbRsp_type;

   typedef struct packed {
      logic [FDIV_W-1:0] divCnt;
      logic [HIST_W-1:0] hist;
      logic              level;
   } filter_type;

   typedef struct packed {
      logic [SYNC_STAGES-1:0] syncPipe;
      logic [1:0]             startCnt;
      logic                   modeValid;
      logic                   manual;
      logic                   armed;
      logic                   prevLevel;
      logic [PRE_W-1:0]       preCnt;
      logic [CMP_W-1:0]       cmpCnt;
      logic                   ctrlRun;
      logic [1:0]             status;
      logic [1:0]             mask;
      ledPair_type            leds;
      logic                   irq;
      logic                   dphValid;
      logic                   dphWrite;
      logic [7:0]             dphAddr;
      ahbRsp_type             rsp;
   } blink_type;

endpackage : blink_pkg

// ---- src/switch_noise_filter.sv ----
module switch_noise_filter #(
   parameter int DIV     = blink_pkg::FILTER_DIV,
   parameter int SAMPLES = blink_pkg::FILTER_SAMPLES
) (
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic sys_rst,
   // Synchronised switch level in, filtered level out
   input  wire logic rawLevel,
   output logic      filtLevel
);
   import blink_pkg::*;

   localparam logic [FDIV_W-1:0] DIV_LAST = FDIV_W'(DIV - 1);
   localparam logic [HIST_W-1:0] ALL_ONE  = {HIST_W{1'b1}};
   localparam logic [HIST_W-1:0] ALL_ZERO = {HIST_W{1'b0}};

   filter_type s_q;
   filter_type s_d;
   logic       sampleTick;

   // Sample every DIV clocks, accept after HIST_W equal samples
   always_comb begin
      s_d        = s_q;
      sampleTick = (s_q.divCnt == DIV_LAST);
      s_d.divCnt = sampleTick ? '0 : s_q.divCnt + 1'b1;
      if (sampleTick) begin
         s_d.hist = {s_q.hist[HIST_W-2:0], rawLevel};
         if (s_d.hist == ALL_ONE) begin
            s_d.level = 1'b1; // RQ7
         end else if (s_d.hist == ALL_ZERO) begin
            s_d.level = 1'b0; // RQ7
         end
      end
   end

   // State register, released level after reset
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         s_q <= '{divCnt: '0, hist: ALL_ONE, level: 1'b1};
      end else begin
         s_q <= s_d;
      end
   end

   assign filtLevel = s_q.level;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   filter_changes_sampled_a : assert property ( // RQ7
      !$stable(s_q.level) |-> $past(sampleTick) && (s_q.hist == {HIST_W{s_q.level}}))
      else $error("filter level moved without agreeing samples");

endmodule : switch_noise_filter

// ---- src/led_blink_mode_controller.sv ----
// How it works
// RQ1 - After reset, sample switch: held down means manual, released means automatic.
// RQ2 - Automatic mode timer counts on the clock divided by 512.
// RQ3 - Automatic mode timer raises a compare event every 500 ms.
// RQ4 - Each timer event or accepted press swaps the two indicators.
// RQ5 - Switch events are ignored unless manual mode was entered.
// RQ6 - In manual mode a press is a falling edge of the switch.
// RQ7 - Switch passes a noise filter sampled at clock divided by 64 first.
// RQ8 - Timer and switch events are both raised at interrupt level 15.
// RQ9 - After reset the indicators stand opposite, first lit, second dark.
//
// Implementation choices: the AHB-Lite interface to the registers and the placing of the registers.
module led_blink_mode_controller #(
   parameter int COMPARE_TICKS = blink_pkg::CMP_TICKS,
   parameter int PRESCALE      = blink_pkg::TIMER_DIV,
   parameter int FILTER_DIV    = blink_pkg::FILTER_DIV
) (
   // Clock and reset
   input  wire logic             core_clk,
   input  wire logic             sys_rst,
   // Register bus
   input  wire blink_pkg::ahbReq_type ahbReq,
   output blink_pkg::ahbRsp_type      ahbRsp,
   // Push button, low while pressed
   input  wire logic             userSwitchN,
   // Indicators and interrupt
   output blink_pkg::ledPair_type     leds,
   output logic                       irq
);
   import blink_pkg::*;

   localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(PRESCALE - 1);
   localparam logic [CMP_W-1:0] CMP_LAST = CMP_W'(COMPARE_TICKS - 1);
   localparam logic [1:0]       START_DONE = 2'(SYNC_STAGES);

   blink_type s_q;
   blink_type s_d;
   logic      filtLevel;
   logic      runTimer;
   logic      preTick;
   logic      tmrEvt;
   logic      swEvt;
   logic      addrPhase;
   logic [1:0] w1c;

   // Digital filter on the synchronised switch
   switch_noise_filter #(
      .DIV     (FILTER_DIV),
      .SAMPLES (FILTER_SAMPLES)
   ) switch_noise_filter_inst (
      .core_clk  (core_clk),
      .sys_rst   (sys_rst),
      .rawLevel  (s_q.syncPipe[SYNC_STAGES-1]),
      .filtLevel (filtLevel)
   );

   // Register read multiplexer
   function automatic logic [31:0] readReg(input logic [7:0] addr, input blink_type s);
      logic [31:0] r;
      r = '0;
      case (addr)
         OFF_CTRL:   r[CTRL_RUN] = s.ctrlRun;
         OFF_STATE: begin
            r[ST_MANUAL] = s.manual;
            r[ST_FIRST]  = s.leds.indicatorFirst;
            r[ST_SECOND] = s.leds.indicatorSecond;
            r[ST_VALID]  = s.modeValid;
         end
         OFF_STATUS: r[1:0] = s.status;
         OFF_MASK:   r[1:0] = s.mask;
         OFF_PRIO: begin
            r[3:0]                     = PRIO_VALUE; // RQ8
            r[PRIO_SW_LSB +: 4]        = PRIO_VALUE; // RQ8
         end
         OFF_COUNT:  r[CMP_W-1:0] = s.cmpCnt;
         default:    r = '0;
      endcase
      return r;
   endfunction : readReg

   // Next state of the whole block
   always_comb begin
      s_d = s_q;

      // Two-stage switch synchroniser
      s_d.syncPipe = {s_q.syncPipe[SYNC_STAGES-2:0], userSwitchN};

      // Mode capture once the synchroniser holds the post-reset level
      if (!s_q.modeValid) begin
         if (s_q.startCnt == START_DONE) begin
            s_d.modeValid = 1'b1; // RQ1
            s_d.manual    = ~s_q.syncPipe[SYNC_STAGES-1]; // RQ1
         end else begin
            s_d.startCnt = s_q.startCnt + 1'b1;
         end
      end

      // Prescaler and compare counter, automatic mode only
      runTimer = s_q.modeValid && !s_q.manual && s_q.ctrlRun;
      preTick  = runTimer && (s_q.preCnt == PRE_LAST); // RQ2
      tmrEvt   = preTick && (s_q.cmpCnt == CMP_LAST); // RQ3
      if (!runTimer) begin
         s_d.preCnt = '0;
         s_d.cmpCnt = '0;
      end else begin
         s_d.preCnt = preTick ? '0 : s_q.preCnt + 1'b1; // RQ2
         if (tmrEvt) begin
            s_d.cmpCnt = '0; // RQ3
         end else if (preTick) begin
            s_d.cmpCnt = s_q.cmpCnt + 1'b1;
         end
      end

      // Press path: armed after a released level in manual mode
      s_d.prevLevel = filtLevel;
      // Raw line must read released too, so a button held through reset is no press
      if (s_q.modeValid && s_q.manual && filtLevel && s_q.syncPipe[SYNC_STAGES-1]) begin
         s_d.armed = 1'b1; // RQ5 RQ6
      end
      swEvt = s_q.armed && s_q.manual && s_q.prevLevel && !filtLevel; // RQ5 RQ6

      // Swap the indicators on either event
      if (tmrEvt || swEvt) begin
         s_d.leds.indicatorFirst  = s_q.leds.indicatorSecond; // RQ4
         s_d.leds.indicatorSecond = s_q.leds.indicatorFirst;  // RQ4
      end

      // Bus address phase: register read data for the data phase
      addrPhase    = ahbReq.hsel && ahbReq.htrans[1] && ahbReq.hready;
      s_d.dphValid = addrPhase;
      s_d.dphWrite = addrPhase && ahbReq.hwrite;
      s_d.dphAddr  = ahbReq.haddr[7:0];
      s_d.rsp.hreadyout = 1'b1;
      s_d.rsp.hresp     = HRESP_OKAY;
      s_d.rsp.hrdata    = (addrPhase && !ahbReq.hwrite) ? readReg(ahbReq.haddr[7:0], s_q) : '0;

      // Bus data phase writes
      w1c = '0;
      if (s_q.dphValid && s_q.dphWrite) begin
         case (s_q.dphAddr)
            OFF_CTRL:   s_d.ctrlRun = ahbReq.hwdata[CTRL_RUN];
            OFF_STATUS: w1c = ahbReq.hwdata[1:0];
            OFF_MASK:   s_d.mask = ahbReq.hwdata[1:0];
            default:    w1c = '0;
         endcase
      end

      // Sticky event bits, a new event wins over the clear
      s_d.status = (s_q.status & ~w1c) | {swEvt, tmrEvt}; // RQ8
      s_d.irq    = |(s_d.status & s_d.mask); // RQ8
   end

   // State register
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         s_q           <= '0;
         s_q.syncPipe  <= {SYNC_STAGES{1'b1}};
         s_q.prevLevel <= 1'b1;
         s_q.ctrlRun   <= CTRL_RUN_RESET;
         s_q.mask      <= MASK_RESET;
         s_q.leds      <= '{indicatorFirst: 1'b1, indicatorSecond: 1'b0}; // RQ9
         s_q.rsp       <= '{hreadyout: 1'b1, hresp: HRESP_OKAY, hrdata: '0};
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from the state register
   assign ahbRsp = s_q.rsp;
   assign leds   = s_q.leds;
   assign irq    = s_q.irq;

   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   leds_stay_opposite_a : assert property ( // RQ9
      s_q.leds.indicatorFirst != s_q.leds.indicatorSecond)
      else $error("indicators are not opposite");

   event_swaps_leds_a : assert property ( // RQ4
      (tmrEvt || swEvt) |=> (s_q.leds.indicatorFirst == $past(s_q.leds.indicatorSecond))
         && (s_q.leds.indicatorSecond == $past(s_q.leds.indicatorFirst)))
      else $error("event did not swap indicators");

   leds_hold_quiet_a : assert property ( // RQ4
      !(tmrEvt || swEvt) |=> $stable(s_q.leds))
      else $error("indicators moved without an event");

   mode_capture_a : assert property ( // RQ1
      (!s_q.modeValid && s_q.startCnt == START_DONE) |=>
         s_q.modeValid && (s_q.manual == !$past(s_q.syncPipe[SYNC_STAGES-1])))
      else $error("mode not captured from switch level");

   mode_held_a : assert property ( // RQ1
      s_q.modeValid |=> s_q.modeValid && $stable(s_q.manual))
      else $error("mode changed after capture");

   auto_ignores_switch_a : assert property ( // RQ5
      !(s_q.modeValid && s_q.manual) |-> !swEvt)
      else $error("switch acted outside manual mode");

   press_falling_edge_a : assert property ( // RQ6
      swEvt |-> $past(filtLevel) && !filtLevel)
      else $error("press without falling edge");

   prescale_spacing_a : assert property ( // RQ2
      preTick |=> !preTick [*8])
      else $error("prescaler ticks too close");

   compare_match_a : assert property ( // RQ3
      tmrEvt |-> preTick && s_q.cmpCnt == CMP_LAST && runTimer)
      else $error("compare event at wrong count");

   event_sets_status_a : assert property ( // RQ8
      tmrEvt |=> s_q.status[EVT_TIMER])
      else $error("timer event lost in status");

   irq_follows_mask_a : assert property ( // RQ8
      s_q.irq == |(s_q.status & s_q.mask))
      else $error("interrupt output disagrees with status and mask");

   prio_reads_level_a : assert property ( // RQ8
      (addrPhase && !ahbReq.hwrite && ahbReq.haddr[7:0] == OFF_PRIO) |=>
         s_q.rsp.hrdata[3:0] == PRIO_VALUE && s_q.rsp.hrdata[7:4] == PRIO_VALUE)
      else $error("priority register wrong");

   state_reads_leds_a : assert property ( // RQ4
      (addrPhase && !ahbReq.hwrite && ahbReq.haddr[7:0] == OFF_STATE) |=>
         s_q.rsp.hrdata[ST_FIRST] == $past(s_q.leds.indicatorFirst))
      else $error("state register shows wrong indicator");

   // Timer checks
   timer_auto_only_a : assert property ( // RQ2
      tmrEvt |-> s_q.modeValid && !s_q.manual)
      else $error("timer event outside automatic mode");

   stopped_timer_zero_a : assert property ( // RQ2
      !runTimer |=> s_q.preCnt == '0 && s_q.cmpCnt == '0)
      else $error("stopped timer kept counting");

   prescale_bound_a : assert property ( // RQ2
      s_q.preCnt <= PRE_LAST)
      else $error("prescaler past its last count");

   compare_bound_a : assert property ( // RQ3
      s_q.cmpCnt <= CMP_LAST)
      else $error("compare count past its last value");

   tick_advances_count_a : assert property ( // RQ2
      (preTick && !tmrEvt) |=> s_q.cmpCnt == $past(s_q.cmpCnt) + 1'b1)
      else $error("divided tick did not advance compare count");

   event_spacing_a : assert property ( // RQ3
      tmrEvt |=> !tmrEvt [*8])
      else $error("compare events too close");

   ctrl_write_a : assert property ( // RQ3
      (s_q.dphValid && s_q.dphWrite && s_q.dphAddr == OFF_CTRL) |=>
         s_q.ctrlRun == $past(ahbReq.hwdata[CTRL_RUN]))
      else $error("run control not written");

   // Mode and press checks
   mode_capture_time_a : assert property ( // RQ1
      $rose(s_q.modeValid) |-> $past(s_q.startCnt) == START_DONE)
      else $error("mode captured at wrong time");

   no_event_before_mode_a : assert property ( // RQ1
      !s_q.modeValid |-> !tmrEvt && !swEvt)
      else $error("event before mode was chosen");

   arm_needs_release_a : assert property ( // RQ6
      (!s_q.armed && s_d.armed) |-> s_q.syncPipe[SYNC_STAGES-1] && filtLevel)
      else $error("press path armed while button held");

   press_spacing_a : assert property ( // RQ7
      swEvt |=> !swEvt [*5])
      else $error("presses closer than the filter allows");

   // Status and interrupt checks
   switch_sets_status_a : assert property ( // RQ8
      swEvt |=> s_q.status[EVT_SWITCH])
      else $error("switch event lost in status");

   status_sticky_a : assert property ( // RQ8
      (s_q.status[EVT_SWITCH] && !w1c[EVT_SWITCH]) |=> s_q.status[EVT_SWITCH])
      else $error("switch status dropped without a clear");

   status_clear_a : assert property ( // RQ8
      (w1c[EVT_TIMER] && !tmrEvt) |=> !s_q.status[EVT_TIMER])
      else $error("timer status not cleared");

   mask_write_a : assert property ( // RQ8
      (s_q.dphValid && s_q.dphWrite && s_q.dphAddr == OFF_MASK) |=>
         s_q.mask == $past(ahbReq.hwdata[1:0]))
      else $error("mask not written");

   masked_irq_low_a : assert property ( // RQ8
      s_q.mask == '0 |-> !s_q.irq)
      else $error("interrupt raised with everything masked");

   // Scenario covers
   timer_event_c : cover property (tmrEvt);
   switch_event_c : cover property (swEvt);
   irq_raised_c : cover property (!s_q.irq ##1 s_q.irq);
   manual_mode_c : cover property ($rose(s_q.modeValid) && s_q.manual);
   status_clear_c : cover property (s_q.status[EVT_TIMER] && w1c[EVT_TIMER]);

endmodule : led_blink_mode_controller

// ---- testbench/switch_led_model.sv ----
module switch_led_model (
   // Clock
   input  wire logic                   core_clk,
   // Bench requests
   input  wire logic                   pressed,
   input  wire logic                   glitch,
   // Button line, pulled up, low while pressed
   output logic                        userSwitchN,
   // Indicators seen by the user, and both lit at once
   input  wire blink_pkg::ledPair_type leds,
   output logic                        litBoth
);
   timeunit 1ns;
   timeprecision 1ps;
   import blink_pkg::*;
   logic [1:0] bounceQ = 2'h0;

   // Contacts chatter high for one clock just after a press
   always_ff @(posedge core_clk) begin
      bounceQ <= {bounceQ[0], pressed};
   end
   assign userSwitchN = ~(glitch | (pressed & ~(bounceQ[0] & ~bounceQ[1])));
   // Both lamps lit at once is what the user would notice
   assign litBoth = leds.indicatorFirst & leds.indicatorSecond;
endmodule : switch_led_model

// ---- testbench/test_led_blink_mode_controller.sv ----
module test_led_blink_mode_controller;
   timeunit 1ns;
   timeprecision 1ps;
   import blink_pkg::*;
   localparam int TICKS = 4;
   localparam int PRE   = 16;
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] expVal;
   } row_type;
   logic        core_clk;
   logic        sys_rst;
   logic        pressed;
   logic        glitch;
   logic        userSwitchN;
   logic        irq;
   ahbReq_type  reqQ;
   ahbReq_type  busReq;
   ahbRsp_type  ahbRsp;
   ledPair_type leds;
   logic        litBoth;
   logic        sawBoth = 1'b0;
   logic        respSeen;
   int          errCount;
   int          testsRun;
   int          c;
   logic [31:0] v;
   row_type     rows [6];

   // Clock
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   // Sticky flag for both indicators lit at once
   always @(posedge core_clk) begin
      if (litBoth === 1'b1) begin
         sawBoth <= 1'b1;
      end
   end

   // Single slave, so its hreadyout is the bus hready
   always_comb begin
      busReq = reqQ;
      busReq.hready = ahbRsp.hreadyout;
   end

   led_blink_mode_controller #(
      .COMPARE_TICKS(TICKS),
      .PRESCALE     (PRE),
      .FILTER_DIV   (4)
   ) led_blink_mode_controller_inst (
      .core_clk   (core_clk),
      .sys_rst    (sys_rst),
      .ahbReq     (busReq),
      .ahbRsp     (ahbRsp),
      .userSwitchN(userSwitchN),
      .leds       (leds),
      .irq        (irq)
   );

   switch_led_model switch_led_model_inst (
      .core_clk   (core_clk),
      .pressed    (pressed),
      .glitch     (glitch),
      .userSwitchN(userSwitchN),
      .leds       (leds),
      .litBoth    (litBoth)
   );

   task chk(input string name, input logic [31:0] expVal, input logic [31:0] got);
      testsRun++;
      if (got !== expVal) begin
         errCount++;
         $display("wrong value %s expected %h seen %h", name, expVal, got);
      end
   endtask : chk

   // One single word transfer, waiting on hready in both phases
   task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
      int n;
      reqQ.hsel   <= 1'b1;
      reqQ.haddr  <= {24'h000000, a};
      reqQ.htrans <= HTRANS_NONSEQ;
      reqQ.hwrite <= w;
      reqQ.hsize  <= 3'h2;
      n = 0;
      do begin @(posedge core_clk); n++; end while (ahbRsp.hreadyout !== 1'b1 && n < 50);
      if (n >= 50) begin
         errCount++;
      end
      reqQ.hsel   <= 1'b0;
      reqQ.htrans <= 2'h0;
      reqQ.hwdata <= wd;
      n = 0;
      do begin @(posedge core_clk); n++; end while (ahbRsp.hreadyout !== 1'b1 && n < 50);
      if (n >= 50) begin
         errCount++;
      end
      rd = ahbRsp.hrdata;
      respSeen = ahbRsp.hresp;
   endtask : ahb

   task rdChk(input string name, input logic [7:0] a, input logic [31:0] expVal);
      logic [31:0] d;
      ahb(1'b0, a, 32'h0, d);
      chk(name, expVal, d);
      chk("bus response", {31'h0, HRESP_OKAY}, {31'h0, respSeen});
   endtask : rdChk

   // Counts clocks until the indicators change
   task waitSwap(output int cyc);
      ledPair_type l0;
      l0 = leds;
      cyc = 0;
      do begin @(posedge core_clk); cyc++; end while (leds === l0 && cyc < 400);
   endtask : waitSwap

   task doReset(input logic held);
      @(posedge core_clk);
      pressed <= held;
      sys_rst <= 1'b1;
      repeat (12) @(posedge core_clk);
      sys_rst <= 1'b0;
      repeat (4) @(posedge core_clk);
   endtask : doReset

   task endOfTest;
      $display("checks %0d mismatches %0d", testsRun, errCount);
      if (errCount == 0 && testsRun > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : endOfTest

   // Watchdog against a hung handshake
   initial begin
      #(8 * 20000);
      errCount++;
      endOfTest();
   end

   // Main sequence
   initial begin
      reqQ = '0;
      sys_rst = 1'b1;
      pressed = 1'b0;
      glitch = 1'b0;
      errCount = 0;
      testsRun = 0;
      rows = '{'{OFF_CTRL, 32'h1}, '{OFF_STATE, 32'hA}, '{OFF_STATUS, 32'h0},
               '{OFF_MASK, 32'h0}, '{OFF_PRIO, 32'hFF}, '{8'h20, 32'h0}};
      doReset(1'b0);
      chk("leds after reset", 32'h2, {30'h0, leds});
      foreach (rows[i]) rdChk("register", rows[i].addr, rows[i].expVal);
      $display("test reset and registers done");
      ahb(1'b1, OFF_MASK, 32'h1, v);
      waitSwap(c);
      chk("leds first swap", 32'h1, {30'h0, leds});
      waitSwap(c);
      chk("timer period", PRE * TICKS, c);
      chk("timer irq", 32'h1, {31'h0, irq});
      ahb(1'b1, OFF_STATUS, 32'h1, v);
      rdChk("status cleared", OFF_STATUS, 32'h0);
      chk("irq cleared", 32'h0, {31'h0, irq});
      $display("test automatic mode done");
      ahb(1'b1, OFF_CTRL, 32'h0, v);
      pressed <= 1'b1;
      repeat (100) @(posedge core_clk);
      pressed <= 1'b0;
      repeat (100) @(posedge core_clk);
      chk("leds auto press", 32'h2, {30'h0, leds});
      rdChk("status auto press", OFF_STATUS, 32'h0);
      rdChk("count stopped", OFF_COUNT, 32'h0);
      $display("test switch ignored done");
      doReset(1'b1);
      rdChk("state manual", OFF_STATE, 32'hB);
      repeat (40) @(posedge core_clk);
      chk("leds held through reset", 32'h2, {30'h0, leds});
      pressed <= 1'b0;
      repeat (300) @(posedge core_clk);
      chk("leds manual idle", 32'h2, {30'h0, leds});
      glitch <= 1'b1;
      repeat (2) @(posedge core_clk);
      glitch <= 1'b0;
      repeat (100) @(posedge core_clk);
      chk("leds after glitch", 32'h2, {30'h0, leds});
      ahb(1'b1, OFF_MASK, 32'h2, v);
      pressed <= 1'b1;
      waitSwap(c);
      chk("press latency", 32'h1, {31'h0, c < 300});
      chk("leds press swap", 32'h1, {30'h0, leds});
      chk("switch irq", 32'h1, {31'h0, irq});
      rdChk("status switch", OFF_STATUS, 32'h2);
      pressed <= 1'b0;
      repeat (200) @(posedge core_clk);
      chk("leds on release", 32'h1, {30'h0, leds});
      $display("test manual mode done");
      chk("indicators both lit", 32'h0, {31'h0, sawBoth});
      endOfTest();
   end
endmodule : test_led_blink_mode_controller
